// *** include/ifs_pkg.sv ***
// constants and types for the two-wire memory slave front end
package ifs_pkg;

  // ----------------------------------------------------------------
  // slave address byte layout
  // ----------------------------------------------------------------
  localparam int         SA_TYPE_MSB = 7;
  localparam int         SA_TYPE_LSB = 4;
  localparam int         SA_SEL_MSB  = 3;
  localparam int         SA_SEL_LSB  = 2;
  localparam int         SA_PAGE_BIT = 1;
  localparam int         SA_RW_BIT   = 0;
  localparam logic [3:0] DEV_TYPE    = 4'ha;
  localparam int         HS_MSB      = 7;
  localparam int         HS_LSB      = 3;
  localparam logic [4:0] HS_CODE     = 5'h01;

  // ----------------------------------------------------------------
  // widths, counts and phases
  // ----------------------------------------------------------------
  localparam int         ADDR_W      = 17;
  localparam int         DATA_W      = 8;
  localparam int         FIFO_DEPTH  = 8;
  localparam logic [3:0] BIT_LAST    = 4'h8;
  localparam logic [3:0] BIT_PRE     = 4'h7;
  localparam logic [3:0] BIT_ZERO    = 4'h0;
  localparam logic [3:0] BIT_ONE     = 4'h1;
  localparam logic [1:0] PH_ADDR_HI  = 2'h0;
  localparam logic [1:0] PH_ADDR_LO  = 2'h1;
  localparam logic [1:0] PH_DATA     = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 17'h00001;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SLAVE = 3'h1,
    ST_RX   = 3'h2,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h4,
    ST_MACK = 3'h5
  } ifs_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ifs_wr_t;

  localparam int WR_W = ADDR_W + DATA_W;

endpackage

// *** rtl/ifs_slave.sv ***
// two-wire slave front end with its write buffer
`timescale 1ns/1ps
// Notes on behaviour
// - first byte after start is slave address
// - respond only when type bits are 1010
// - select bits must match select pins
// - page bit becomes memory address bit 16
// - low bit one reads, zero writes
// - stop: data rises while clock high
// - stop abandons any operation
// - start: data falls while clock high
// - start aborts, expects new slave address
// - sample on clock rise, drive on fall
// - data steady while clock high
// - receiver pulls data low in ninth clock
// - missing acknowledge ends the operation
// - reads continue while master acknowledges
// - master code 00001 enters high speed
// - stop leaves high speed mode
// - all transfers unchanged in high speed
// - write protect high blocks all writes
// - select pins default low when open
// - address is page bit plus two bytes
// - ready again at once after writes
// - address increments per byte, wraps
// - protected writes unacknowledged, address held
// - bytes travel most significant bit first
// - write commits at eighth bit, before ack

// ------------------------------------------------------------------
// write buffer
// ------------------------------------------------------------------
module ifs_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
    logic                ov;
    logic [W-1:0]        head;
  } ifs_fifo_t;

  ifs_fifo_t r;
  ifs_fifo_t next_r;
  logic      full;
  logic      empty;

  // pointers carry one extra bit so full and empty differ
  assign full      = (r.wp[AW-1:0] == r.rp[AW-1:0]) && (r.wp[AW] != r.rp[AW]);
  assign empty     = (r.wp == r.rp);
  assign in_ready  = ~full;
  // head and valid are flops so the array port sees no logic
  assign out_valid = r.ov;
  assign out_data  = r.head;

  always_comb begin
    next_r = r;
    if (in_valid && !full) begin
      next_r.mem[r.wp[AW-1:0]] = in_data;
      next_r.wp = r.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      next_r.rp = r.rp + 1'b1;
    end
    next_r.ov   = (next_r.wp != next_r.rp);
    next_r.head = next_r.mem[next_r.rp[AW-1:0]];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r.mem  <= '0;
      r.wp   <= '0;
      r.rp   <= '0;
      r.ov   <= 1'b0;
      r.head <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

// ------------------------------------------------------------------
// slave front end
// ------------------------------------------------------------------
module ifs_slave (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  // bus pins
  input  wire logic                         scl_in,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe_n,
  // straps
  input  wire logic [1:0]                   device_select_pins,
  input  wire logic                         write_protect,
  // status
  output logic                              hs_mode,
  // array read port, data returned one cycle after the request
  output logic                              mem_rd_req,
  output logic [ifs_pkg::ADDR_W-1:0]        mem_rd_addr,
  input  wire logic [ifs_pkg::DATA_W-1:0]   mem_rd_data,
  // array write port
  output logic                              mem_wr_valid,
  input  wire logic                         mem_wr_ready,
  output logic [ifs_pkg::ADDR_W-1:0]        mem_wr_addr,
  output logic [ifs_pkg::DATA_W-1:0]        mem_wr_data
);

  typedef struct packed {
    logic [2:0]                 scl_s;
    logic [2:0]                 sda_s;
    logic [1:0]                 dsel_m;
    logic [1:0]                 dsel;
    logic                       wp_m;
    logic                       wp;
    ifs_pkg::ifs_state_t        st;
    logic [3:0]                 cnt;
    logic [7:0]                 sh;
    logic [1:0]                 phase;
    logic [ifs_pkg::ADDR_W-1:0] addr;
    logic                       to_tx;
    logic                       ack_ok;
    logic                       mack;
    logic                       hs;
    logic                       sda_oe_n;
    logic                       sda_out;
    logic                       rd_need;
    logic                       rd_req;
    logic                       rd_wait;
    logic [7:0]                 rd_buf;
  } ifs_regs_t;

  ifs_regs_t        r;
  ifs_regs_t        next_r;
  logic             push;
  logic             fifo_ready;
  logic             fifo_valid;
  ifs_pkg::ifs_wr_t push_data;
  ifs_pkg::ifs_wr_t pop_data;

  // wraps from the top address to zero by plain overflow
  function automatic logic [ifs_pkg::ADDR_W-1:0] addr_inc(
    input logic [ifs_pkg::ADDR_W-1:0] a
  );
    addr_inc = a + ifs_pkg::ADDR_ONE;
  endfunction

  // ----------------------------------------------------------------
  // write buffer between the bus and the array
  // ----------------------------------------------------------------
  ifs_fifo #(
    .W (ifs_pkg::WR_W),
    .D (ifs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_data),
    .out_valid (fifo_valid),
    .out_ready (mem_wr_ready),
    .out_data  (pop_data)
  );

  assign mem_wr_valid = fifo_valid;
  assign mem_wr_addr  = pop_data.addr;
  assign mem_wr_data  = pop_data.data;
  assign sda_out      = r.sda_out;
  assign sda_oe_n     = r.sda_oe_n;
  assign hs_mode      = r.hs;
  assign mem_rd_req   = r.rd_req;
  assign mem_rd_addr  = r.addr;

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  always_comb begin
    logic       scl_rise;
    logic       scl_fall;
    logic       scl_high;
    logic       start;
    logic       stop;
    logic [7:0] b;
    next_r    = r;
    push      = 1'b0;
    push_data = '0;
    // stage 0 feeds only stage 1; stages 1 and 2 find edges
    next_r.scl_s  = {r.scl_s[1:0], scl_in};
    next_r.sda_s  = {r.sda_s[1:0], sda_in};
    next_r.dsel_m = device_select_pins;
    next_r.dsel   = r.dsel_m;
    next_r.wp_m   = write_protect;
    next_r.wp     = r.wp_m;
    next_r.rd_req = 1'b0;
    scl_rise = r.scl_s[1] & ~r.scl_s[2];
    scl_fall = ~r.scl_s[1] & r.scl_s[2];
    scl_high = r.scl_s[1] & r.scl_s[2];
    start    = scl_high & ~r.sda_s[1] & r.sda_s[2];
    stop     = scl_high & r.sda_s[1] & ~r.sda_s[2];
    b        = {r.sh[6:0], r.sda_s[1]};

    // array answers one cycle after the request, so wait a cycle
    next_r.rd_wait = r.rd_req;
    if (r.rd_wait) begin
      next_r.rd_buf = mem_rd_data;
    end
    // reads wait for queued writes so they see fresh data
    if (r.rd_need && !fifo_valid) begin
      next_r.rd_req  = 1'b1;
      next_r.rd_need = 1'b0;
    end

    if (stop) begin
      next_r.st       = ifs_pkg::ST_IDLE;
      next_r.hs       = 1'b0;
      next_r.sda_oe_n = 1'b1;
      next_r.rd_need  = 1'b0;
    end else if (start) begin
      next_r.st       = ifs_pkg::ST_SLAVE;
      next_r.cnt      = ifs_pkg::BIT_ZERO;
      next_r.sda_oe_n = 1'b1;
      next_r.rd_need  = 1'b0;
    end else begin
      case (r.st)
        ifs_pkg::ST_IDLE: begin
          next_r.sda_oe_n = 1'b1;
        end
        ifs_pkg::ST_SLAVE: begin
          if (scl_rise) begin
            next_r.sh  = b;
            next_r.cnt = r.cnt + 1'b1;
            if (r.cnt == ifs_pkg::BIT_PRE) begin
              next_r.ack_ok = 1'b0;
              if (b[ifs_pkg::HS_MSB:ifs_pkg::HS_LSB] == ifs_pkg::HS_CODE)
              begin
                // master code is never acknowledged
                next_r.hs = 1'b1;
              end else if (
                  b[ifs_pkg::SA_TYPE_MSB:ifs_pkg::SA_TYPE_LSB]
                    == ifs_pkg::DEV_TYPE &&
                  b[ifs_pkg::SA_SEL_MSB:ifs_pkg::SA_SEL_LSB]
                    == r.dsel) begin
                next_r.ack_ok = 1'b1;
                next_r.addr[ifs_pkg::ADDR_W-1] =
                  b[ifs_pkg::SA_PAGE_BIT];
                next_r.to_tx = b[ifs_pkg::SA_RW_BIT];
                next_r.rd_need = b[ifs_pkg::SA_RW_BIT];
                next_r.phase = ifs_pkg::PH_ADDR_HI;
              end
            end
          end else if (scl_fall && r.cnt == ifs_pkg::BIT_LAST) begin
            next_r.st       = ifs_pkg::ST_ACK;
            next_r.sda_oe_n = ~r.ack_ok;
          end
        end
        ifs_pkg::ST_RX: begin
          if (scl_rise) begin
            next_r.sh  = b;
            next_r.cnt = r.cnt + 1'b1;
            if (r.cnt == ifs_pkg::BIT_PRE) begin
              next_r.ack_ok = 1'b1;
              case (r.phase)
                ifs_pkg::PH_ADDR_HI: begin
                  next_r.addr[15:8] = b;
                  next_r.phase      = ifs_pkg::PH_ADDR_LO;
                end
                ifs_pkg::PH_ADDR_LO: begin
                  next_r.addr[7:0] = b;
                  next_r.phase     = ifs_pkg::PH_DATA;
                end
                default: begin
                  // a full buffer refuses the byte like protection
                  if (!r.wp && fifo_ready) begin
                    push           = 1'b1;
                    push_data.addr = r.addr;
                    push_data.data = b;
                    next_r.addr    = addr_inc(r.addr);
                  end else begin
                    next_r.ack_ok = 1'b0;
                  end
                end
              endcase
            end
          end else if (scl_fall && r.cnt == ifs_pkg::BIT_LAST) begin
            next_r.st       = ifs_pkg::ST_ACK;
            next_r.sda_oe_n = ~r.ack_ok;
          end
        end
        ifs_pkg::ST_ACK: begin
          if (scl_fall) begin
            next_r.sda_oe_n = 1'b1;
            next_r.cnt      = ifs_pkg::BIT_ZERO;
            if (!r.ack_ok) begin
              next_r.st = ifs_pkg::ST_IDLE;
            end else if (r.to_tx) begin
              next_r.st       = ifs_pkg::ST_TX;
              next_r.sh       = {r.rd_buf[6:0], 1'b0};
              next_r.sda_oe_n = r.rd_buf[7];
              next_r.cnt      = ifs_pkg::BIT_ONE;
            end else begin
              next_r.st = ifs_pkg::ST_RX;
            end
          end
        end
        ifs_pkg::ST_TX: begin
          if (scl_fall) begin
            if (r.cnt == ifs_pkg::BIT_LAST) begin
              // release for the master's acknowledge slot
              next_r.sda_oe_n = 1'b1;
              next_r.st       = ifs_pkg::ST_MACK;
              next_r.addr     = addr_inc(r.addr);
              next_r.rd_need  = 1'b1;
            end else begin
              next_r.sda_oe_n = r.sh[7];
              next_r.sh       = {r.sh[6:0], 1'b0};
              next_r.cnt      = r.cnt + 1'b1;
            end
          end
        end
        ifs_pkg::ST_MACK: begin
          if (scl_rise) begin
            next_r.mack = ~r.sda_s[1];
          end else if (scl_fall) begin
            if (r.mack) begin
              next_r.st       = ifs_pkg::ST_TX;
              next_r.sh       = {r.rd_buf[6:0], 1'b0};
              next_r.sda_oe_n = r.rd_buf[7];
              next_r.cnt      = ifs_pkg::BIT_ONE;
            end else begin
              next_r.st = ifs_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          next_r.st       = ifs_pkg::ST_IDLE;
          next_r.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r.scl_s    <= 3'h7;
      r.sda_s    <= 3'h7;
      r.dsel_m   <= 2'h0;
      r.dsel     <= 2'h0;
      r.wp_m     <= 1'b0;
      r.wp       <= 1'b0;
      r.st       <= ifs_pkg::ST_IDLE;
      r.cnt      <= ifs_pkg::BIT_ZERO;
      r.sh       <= 8'h00;
      r.phase    <= ifs_pkg::PH_ADDR_HI;
      r.addr     <= ifs_pkg::ADDR_RST;
      r.to_tx    <= 1'b0;
      r.ack_ok   <= 1'b0;
      r.mack     <= 1'b0;
      r.hs       <= 1'b0;
      r.sda_oe_n <= 1'b1;
      r.sda_out  <= 1'b0;
      r.rd_need  <= 1'b0;
      r.rd_req   <= 1'b0;
      r.rd_wait  <= 1'b0;
      r.rd_buf   <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

endmodule

// *** dv/ifs_slave_checker.sv ***
// port assertions for the two-wire slave front end
`timescale 1ns/1ps
module ifs_slave_checker (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // bus pins, straps and status
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  input  wire logic                       sda_out,
  input  wire logic                       sda_oe_n,
  input  wire logic                       write_protect,
  input  wire logic                       hs_mode,
  // array ports
  input  wire logic                       mem_rd_req,
  input  wire logic                       mem_wr_valid,
  input  wire logic                       mem_wr_ready,
  input  wire logic [ifs_pkg::ADDR_W-1:0] mem_wr_addr,
  input  wire logic [ifs_pkg::DATA_W-1:0] mem_wr_data
);
  // ----------------------------------------------
  // line conditions seen at the pins
  // ----------------------------------------------
  logic scl_q;
  logic sda_q;
  logic start_seen;
  logic stop_seen;
  always_ff @(posedge sys_clk) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
  end
  assign start_seen = scl_in && scl_q && sda_q && !sda_in;
  assign stop_seen  = scl_in && scl_q && !sda_q && sda_in;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_OPEN_DRAIN: assert property (!sda_oe_n |-> !sda_out)
    else $error("data pin driven high");
  AST_QUIET_HIGH: assert property (
    $changed(sda_oe_n) |-> !scl_in)
    else $error("data drive changed while clock high");
  AST_START_FREE: assert property (start_seen |-> ##[1:6] sda_oe_n)
    else $error("data still driven after start");
  AST_STOP_SPEED: assert property (stop_seen |-> ##[1:6] !hs_mode)
    else $error("high speed kept after stop");
  AST_HS_NO_ACK: assert property (
    $rose(hs_mode) |-> scl_in && sda_oe_n)
    else $error("high speed entered wrongly");
  AST_RD_PULSE: assert property (mem_rd_req |=> !mem_rd_req)
    else $error("read request longer than one cycle");
  AST_RD_EMPTY: assert property (mem_rd_req |-> !mem_wr_valid)
    else $error("read issued before writes drained");
  AST_WR_HOLD: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
    else $error("pending write changed");
  // protect level two sync stages plus push and buffer flop ago
  AST_WP_BLOCK: assert property ($rose(mem_wr_valid) |->
    !$past(write_protect, 3) && scl_in)
    else $error("write pushed while protected or off clock high");
endmodule

bind ifs_slave ifs_slave_checker u_chk (
  .sys_clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe_n, .write_protect,
  .hs_mode, .mem_rd_req, .mem_wr_valid, .mem_wr_ready, .mem_wr_addr,
  .mem_wr_data
);

// *** dv/ifs_master_model.sv ***
// two-wire bus master model: clock and open-drain data
`timescale 1ns/1ps
module ifs_master_model (
  // bus lines
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  // quarter of a 125 ns bus clock period
  localparam realtime Q = 31.25;
  logic r;
  initial begin
    scl   = 1'b1;  // clock stands high outside frames
    sda_m = 1'b1;
  end
  task automatic start();
    sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #Q;
  endtask
  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    sda_m = b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!mack, r);
  endtask
endmodule

// *** dv/ifs_slave_tb_top.sv ***
// self-checking bench for the two-wire slave front end
`timescale 1ns/1ps
module ifs_slave_tb_top;
  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] sa;
    logic       ack;
    logic       hs;
  } ifs_row_t;
  // ----------------------------------------------
  // decode rows: straps, slave byte, ack, speed
  // ----------------------------------------------
  ifs_row_t   rows [8] = '{
    '{2'h0, 8'ha0, 1'b1, 1'b0}, '{2'h1, 8'ha4, 1'b1, 1'b0},
    '{2'h0, 8'ha4, 1'b0, 1'b0}, '{2'h3, 8'hbc, 1'b0, 1'b0},
    '{2'h3, 8'h2c, 1'b0, 1'b0}, '{2'h3, 8'hac, 1'b1, 1'b0},
    '{2'h0, 8'h08, 1'b0, 1'b1}, '{2'h0, 8'h0f, 1'b0, 1'b1}};
  logic [7:0] wa [6] = '{8'haa, 8'hff, 8'hfe, 8'h11, 8'h22, 8'h33};
  logic       sys_clk, rst_n, scl, sda_m, sda, wp, stall, a;
  logic       oe_n, sda_o, hs, rd_req, wr_valid;
  logic [1:0] sel;
  logic [16:0] rd_addr, wr_addr;
  logic [7:0] rd_data, wr_data, d;
  logic [7:0] mem [0:131071];
  int         failures, comparisons;

  // released data line floats to the pull-up level
  assign sda = sda_m & (oe_n | sda_o);

  ifs_master_model m (.scl(scl), .sda_m(sda_m), .sda(sda));
  ifs_slave dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_n(oe_n), .device_select_pins(sel),
    .write_protect(wp), .hs_mode(hs), .mem_rd_req(rd_req),
    .mem_rd_addr(rd_addr), .mem_rd_data(rd_data),
    .mem_wr_valid(wr_valid), .mem_wr_ready(!stall),
    .mem_wr_addr(wr_addr), .mem_wr_data(wr_data));

  // array model: read data valid only in the cycle after the request
  initial mem[17'h10010] = 8'h5a;
  always @(posedge sys_clk) begin
    rd_data <= rd_req ? mem[rd_addr] : ~rd_data;
    if (wr_valid && !stall) mem[wr_addr] <= wr_data;
  end

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic exp);
    m.wr_byte(b, a);
    chk(a, exp);
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #500us;
    failures++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    sel   = 2'h0;
    wp    = 1'b0;
    stall = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(oe_n, 1'b1);
    chk(hs, 1'b0);
    $display("reset state done");
    foreach (rows[i]) begin
      @(posedge sys_clk) sel <= rows[i].sel;
      m.start();
      send(rows[i].sa, rows[i].ack);
      chk(hs, rows[i].hs);
      m.stop();
      repeat (4) @(posedge sys_clk);
      chk(hs, 1'b0);
    end
    $display("decode table done");
    @(posedge sys_clk) sel <= 2'h2;
    m.start();
    send(8'h08, 1'b0);
    m.start();
    foreach (wa[i]) send(wa[i], 1'b1);
    m.stop();
    repeat (20) @(posedge sys_clk);
    chk(mem[17'h1fffe], 8'h11);
    chk(mem[17'h1ffff], 8'h22);
    chk(mem[17'h00000], 8'h33);
    $display("high speed write done");
    m.start();
    send(8'haa, 1'b1);
    send(8'hff, 1'b1);
    send(8'hff, 1'b1);
    m.start();
    send(8'hab, 1'b1);
    m.rd_byte(1'b1, d);
    chk(d, 8'h22);
    m.rd_byte(1'b0, d);
    chk(d, 8'h33);
    m.stop();
    $display("random read done");
    @(posedge sys_clk) wp <= 1'b1;
    m.start();
    send(8'haa, 1'b1);
    send(8'h00, 1'b1);
    send(8'h10, 1'b1);
    send(8'h55, 1'b0);
    m.stop();
    @(posedge sys_clk) wp <= 1'b0;
    m.start();
    send(8'hab, 1'b1);
    m.rd_byte(1'b0, d);
    chk(d, 8'h5a);
    m.stop();
    $display("write protect done");
    m.start();
    send(8'haa, 1'b1);
    send(8'h00, 1'b1);
    send(8'h10, 1'b1);
    for (int i = 0; i < 5; i++) m.bit_io(1'b0, a);
    m.stop();
    repeat (20) @(posedge sys_clk);
    chk(mem[17'h10010], 8'h5a);
    $display("stop abort done");
    @(posedge sys_clk) stall <= 1'b1;
    m.start();
    send(8'haa, 1'b1);
    send(8'h01, 1'b1);
    send(8'h00, 1'b1);
    for (int i = 0; i < 8; i++) send(8'h40 + i[7:0], 1'b1);
    send(8'hee, 1'b0);
    m.stop();
    @(posedge sys_clk) stall <= 1'b0;
    repeat (20) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      chk(mem[17'h10100 + i[16:0]], 8'h40 + i[7:0]);
    end
    chk(wr_valid, 1'b0);
    $display("buffer full done");
    // reset in mid-frame with high speed set and the clock line low
    m.start();
    send(8'h08, 1'b0);
    chk(hs, 1'b1);
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(hs, 1'b0);
    chk(oe_n, 1'b1);
    m.stop();
    repeat (4) @(posedge sys_clk);
    chk(hs, 1'b0);
    $display("mid-run reset done");
    conclude();
  end
endmodule
